/* File: logic/mpcef_pkg.sv */
// package: constants and register layouts of the chopper and event filter block
package mpcef_pkg;
  localparam int unsigned CLOCK_HZ = 25000000;
  localparam int unsigned PERIPH_REF_HZ = 4000000;
  // register byte offsets on the avalon slave
  localparam logic [3:0] OFS_D_FILTER = 4'h0;
  localparam logic [3:0] OFS_REFERENCE = 4'h4;
  localparam logic [3:0] OFS_PWM_CTRL = 4'h8;
  localparam logic [3:0] OFS_SENSOR = 4'hC;
  // reset values
  localparam logic [7:0] RST_D_FILTER = 8'h0F;
  localparam logic [7:0] RST_REFERENCE = 8'h00;
  localparam logic [7:0] RST_PWM_CTRL = 8'h00;
  localparam logic [7:0] RST_SENSOR = 8'h00;
  // field positions of the reference register
  localparam int unsigned POS_BEMF_STATE = 7;
  localparam int unsigned POS_CURRENT_STATE = 6;
  localparam int unsigned POS_CURRENT_SEL = 5;
  // blanking step: 5 us, counted in clock cycles (rounded down, a longest time)
  localparam int unsigned BLANK_STEP_NS = 5000;
  localparam int unsigned BLANK_STEP_CYCLES = BLANK_STEP_NS / (1000000000 / CLOCK_HZ);
  localparam int unsigned BLANK_LONG_STEP_FACTOR = 4;
  localparam logic [3:0] BLANK_LONG_CODE_BASE = 4'h8;
  localparam logic [3:0] BLANK_LONG_CODE_OFFSET = 4'h5;
  // chopper frequencies in Hz for codes 0..7
  localparam int unsigned CHOP_HZ [8] = '{100000, 200000, 400000, 500000,
                                          800000, 1000000, 1333333, 2000000};
  // chop mode encodings
  localparam logic [1:0] CHOP_OFF = 2'h0;
  localparam logic [1:0] CHOP_LOW = 2'h1;
  localparam logic [1:0] CHOP_HIGH = 2'h2;
  localparam logic [1:0] CHOP_BOTH = 2'h3;
  // compare masks for the two compare formats
  localparam logic [15:0] CMP_MASK_STANDARD = 16'hFFF8;
  localparam logic [15:0] CMP_MASK_EIGHT_BIT = 16'hFF00;

  typedef struct packed {
    logic [3:0] d_event_sample_count;
    logic [3:0] d_blanking_window;
  } mpcef_d_filter_t;

  typedef struct packed {
    logic bemf_comparator_state;
    logic current_limit_comparator_state;
    logic current_input_select;
    logic [1:0] chop_mode_select;
    logic [2:0] chop_rate_select;
  } mpcef_reference_t;

  typedef struct packed {
    logic pwm_eight_bit_mode;
    logic phase_u_full_duty;
    logic phase_v_full_duty;
    logic phase_w_full_duty;
    logic counter_alignment_select;
    logic [2:0] pwm_clock_divider;
  } mpcef_pwm_ctrl_t;

  typedef enum logic [1:0] {
    MPCEF_IDLE = 2'b00,
    MPCEF_WAIT = 2'b01,
    MPCEF_DONE = 2'b10
  } mpcef_bus_state_t;
endpackage : mpcef_pkg

/* File: logic/mpcef_top.sv */
// module: d event filter, comparator read-back, chopper and pwm counter control
//
// Overview of operation
// [R1] d event after sample count plus one hits
// [R2] filter samples taken on sampling clock ticks
// [R3] blanking window opened at every c event outside rotor sensor mode
// [R4] window codes: 5 us steps, then 20 us
// [R5] rotor sensor mode: no blanking window
// [R6] bemf comparator level readable, read only
// [R7] current comparator level readable, read only
// [R8] select bit picks current comparator input
// [R9] chop mode: off, low, high, both
// [R10] chop rate code picks chopper frequency
// [R11] chopper square wave at 50 percent duty
// [R12] compare format: standard or eight bit
// [R13] full duty forced between update events
// [R14] full duty bits clear after transfer
// [R15] alignment bit: edge or center counting
// [R16] counter clock is clock over divider plus one
// [R17] blanking timed by counting clock cycles
//
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mpcef_top
  import mpcef_pkg::*;
#(
  parameter int unsigned BLANK_STEP = BLANK_STEP_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sampling_clock_tick,
  input wire logic commutation_event,
  input wire logic update_event,
  input wire logic d_event_raw,
  input wire logic bemf_comparator_in,
  input wire logic amplifier_output_cmp,
  input wire logic direct_current_feedback_cmp,
  input wire logic [15:0] pwm_period,
  input wire logic [15:0] phase_compare [3],
  output logic d_event,
  output logic blanking_active,
  output logic current_input_select,
  output logic chop_signal,
  output logic chop_low_enable,
  output logic chop_high_enable,
  output logic [15:0] pwm_counter,
  output logic pwm_counting_up,
  output logic pwm_period_end,
  output logic [2:0] full_duty_active,
  output logic [2:0] compare_extension,
  output logic [15:0] compare_active [3]
);

  // ==========================================================
  // functions
  // blanking length in 5 us steps for a window code
  function automatic logic [5:0] blank_steps(input logic [3:0] code);
    if (code < BLANK_LONG_CODE_BASE) begin
      blank_steps = {2'b00, code} + 6'h01; // [R4]
    end else begin
      blank_steps = 6'(BLANK_LONG_STEP_FACTOR * (code - BLANK_LONG_CODE_OFFSET)); // [R4]
    end
  endfunction : blank_steps

  // half period of the chopper in clock cycles, at least one
  function automatic logic [7:0] chop_half(input logic [2:0] code);
    int unsigned h;
    h = CLOCK_HZ / (2 * CHOP_HZ[code]);
    chop_half = (h == 0) ? 8'h01 : 8'(h);
  endfunction : chop_half

  // ==========================================================
  // registers and pin synchronisers
  mpcef_d_filter_t d_event_filter_config;
  mpcef_reference_t comparator_chopper_reference;
  mpcef_pwm_ctrl_t pwm_counter_control;
  logic rotor_sensor_select;
  logic [2:0] bemf_sync;
  logic [2:0] cur_sync;
  logic [2:0] d_sync;
  logic bemf_level;
  logic cur_level;
  logic d_level;
  logic d_level_prev;
  mpcef_bus_state_t bus_state;

  // current comparator source picked before synchronising
  wire cur_source = comparator_chopper_reference.current_input_select ?
                    direct_current_feedback_cmp : amplifier_output_cmp; // [R8]
  assign current_input_select = comparator_chopper_reference.current_input_select; // [R8]

  // three stages; a level is taken only once stages two and three agree
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      bemf_sync <= 3'h0;
      cur_sync <= 3'h0;
      d_sync <= 3'h0;
      bemf_level <= 1'b0;
      cur_level <= 1'b0;
      d_level <= 1'b0;
    end else begin
      bemf_sync <= {bemf_sync[1:0], bemf_comparator_in};
      cur_sync <= {cur_sync[1:0], cur_source};
      d_sync <= {d_sync[1:0], d_event_raw};
      if (bemf_sync[1] == bemf_sync[2]) bemf_level <= bemf_sync[2];
      if (cur_sync[1] == cur_sync[2]) cur_level <= cur_sync[2];
      if (d_sync[1] == d_sync[2]) d_level <= d_sync[2];
    end
  end

  // ==========================================================
  // avalon slave: one wait state, data and write take effect on release
  wire bus_req = avs_read | avs_write;
  wire bus_ack = (bus_state == MPCEF_WAIT);
  wire wr_go = bus_ack & avs_write & avs_byteenable[0];
  wire wr_filter = wr_go & (avs_address == OFS_D_FILTER);
  wire wr_ref = wr_go & (avs_address == OFS_REFERENCE);
  wire wr_pwm = wr_go & (avs_address == OFS_PWM_CTRL);
  wire wr_sensor = wr_go & (avs_address == OFS_SENSOR);
  wire [7:0] wr_byte = avs_writedata[7:0];
  assign avs_waitrequest = bus_req & ~bus_ack;

  // read mux; comparator bits show live levels, unmapped reads zero
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (avs_address)
      OFS_D_FILTER: rd_byte = d_event_filter_config;
      OFS_REFERENCE: rd_byte = {bemf_level, cur_level, // [R6] [R7]
                                comparator_chopper_reference[5:0]};
      OFS_PWM_CTRL: rd_byte = pwm_counter_control;
      OFS_SENSOR: rd_byte = {7'h00, rotor_sensor_select};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      bus_state <= MPCEF_IDLE;
      avs_readdata <= 32'h00000000;
    end else begin
      unique case (bus_state)
        MPCEF_IDLE: if (bus_req) begin
          bus_state <= MPCEF_WAIT;
          avs_readdata <= {24'h000000, rd_byte};
        end
        MPCEF_WAIT: bus_state <= MPCEF_IDLE;
        default: bus_state <= MPCEF_IDLE;
      endcase
    end
  end

  // ==========================================================
  // register storage; the comparator bits are not stored
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      d_event_filter_config <= RST_D_FILTER;
      comparator_chopper_reference <= RST_REFERENCE;
      rotor_sensor_select <= RST_SENSOR[0];
    end else begin
      if (wr_filter) d_event_filter_config <= wr_byte;
      if (wr_ref) comparator_chopper_reference <= {2'b00, wr_byte[5:0]}; // [R6] [R7]
      if (wr_sensor) rotor_sensor_select <= wr_byte[0];
    end
  end

  // full duty preload bits: cleared once moved across; a write in the
  // same cycle as the update wins, so software is never silently lost
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pwm_counter_control <= RST_PWM_CTRL;
      full_duty_active <= 3'h0;
    end else begin
      if (update_event) begin
        full_duty_active <= pwm_counter_control[6:4]; // [R13]
      end
      if (wr_pwm) begin
        pwm_counter_control <= wr_byte;
      end else if (update_event) begin
        pwm_counter_control[6:4] <= 3'h0; // [R14]
      end
    end
  end

  // ==========================================================
  // blanking window after each c event outside rotor sensor mode, timed in clock cycles
  logic [12:0] blank_tick;
  logic [5:0] blank_left;
  wire blank_start = commutation_event & ~rotor_sensor_select; // [R5]
  assign blanking_active = (blank_left != 6'h00);

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      blank_tick <= 13'h0000;
      blank_left <= 6'h00;
    end else if (blank_start) begin
      blank_tick <= 13'h0000;
      blank_left <= blank_steps(d_event_filter_config.d_blanking_window); // [R3]
    end else if (rotor_sensor_select) begin
      blank_left <= 6'h00; // [R5]
    end else if (blanking_active) begin
      if (blank_tick == 13'(BLANK_STEP - 1)) begin // [R17]
        blank_tick <= 13'h0000;
        blank_left <= blank_left - 6'h01;
      end else begin
        blank_tick <= blank_tick + 13'h0001;
      end
    end
  end

  // ==========================================================
  // d event filter: consecutive hits on sampling ticks, one pulse per run
  logic [4:0] d_hits;
  logic d_fired;
  wire [4:0] d_need = {1'b0, d_event_filter_config.d_event_sample_count} + 5'h01; // [R1]
  wire d_valid = d_level & ~blanking_active; // [R3]

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      d_hits <= 5'h00;
      d_fired <= 1'b0;
      d_event <= 1'b0;
      d_level_prev <= 1'b0;
    end else begin
      d_level_prev <= d_level;
      d_event <= 1'b0;
      if (rotor_sensor_select) begin
        d_event <= d_level & ~d_level_prev; // [R1]
        d_hits <= 5'h00;
        d_fired <= 1'b0;
      end else if (sampling_clock_tick) begin // [R2]
        if (!d_valid) begin
          d_hits <= 5'h00;
          d_fired <= 1'b0;
        end else if (!d_fired) begin
          if (d_hits + 5'h01 == d_need) begin // [R1]
            d_event <= 1'b1;
            d_fired <= 1'b1;
          end
          d_hits <= d_hits + 5'h01;
        end
      end
    end
  end

  // ==========================================================
  // chopper: toggles every half period for an even high and low time
  logic [7:0] chop_count;
  wire chop_on = (comparator_chopper_reference.chop_mode_select != CHOP_OFF);
  wire [7:0] chop_limit = chop_half(comparator_chopper_reference.chop_rate_select); // [R10]

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      chop_count <= 8'h00;
      chop_signal <= 1'b0;
    end else if (!chop_on) begin
      chop_count <= 8'h00;
      chop_signal <= 1'b0;
    end else if (chop_count >= chop_limit - 8'h01) begin
      chop_count <= 8'h00;
      chop_signal <= ~chop_signal; // [R11]
    end else begin
      chop_count <= chop_count + 8'h01;
    end
  end

  // channel groups that receive the chopper
  assign chop_low_enable = (comparator_chopper_reference.chop_mode_select == CHOP_LOW) |
                           (comparator_chopper_reference.chop_mode_select == CHOP_BOTH); // [R9]
  assign chop_high_enable = (comparator_chopper_reference.chop_mode_select == CHOP_HIGH) |
                            (comparator_chopper_reference.chop_mode_select == CHOP_BOTH); // [R9]

  // ==========================================================
  // pwm counter with prescaler and alignment
  logic [2:0] pre_count;
  wire pre_tick = (pre_count == pwm_counter_control.pwm_clock_divider); // [R16]
  wire center = pwm_counter_control.counter_alignment_select; // [R15]

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pre_count <= 3'h0;
      pwm_counter <= 16'h0000;
      pwm_counting_up <= 1'b1;
      pwm_period_end <= 1'b0;
    end else begin
      pwm_period_end <= 1'b0;
      pre_count <= pre_tick ? 3'h0 : pre_count + 3'h1; // [R16]
      if (pre_tick) begin
        if (!center) begin
          pwm_counting_up <= 1'b1;
          if (pwm_counter >= pwm_period) begin // [R15]
            pwm_counter <= 16'h0000;
            pwm_period_end <= 1'b1;
          end else begin
            pwm_counter <= pwm_counter + 16'h0001;
          end
        end else if (pwm_counting_up) begin
          if (pwm_counter >= pwm_period) begin // [R15]
            pwm_counting_up <= 1'b0;
            pwm_counter <= (pwm_period == 16'h0000) ? 16'h0000 : pwm_period - 16'h0001;
            pwm_period_end <= 1'b1;
          end else begin
            pwm_counter <= pwm_counter + 16'h0001;
          end
        end else if (pwm_counter == 16'h0000) begin
          pwm_counting_up <= 1'b1;
          pwm_counter <= 16'h0001;
          pwm_period_end <= 1'b1;
        end else begin
          pwm_counter <= pwm_counter - 16'h0001;
        end
      end
    end
  end

  // ==========================================================
  // compare format: masked active bits and extension bit per phase
  wire [15:0] cmp_mask = pwm_counter_control.pwm_eight_bit_mode ?
                         CMP_MASK_EIGHT_BIT : CMP_MASK_STANDARD; // [R12]
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      compare_extension <= 3'h0;
      for (int i = 0; i < 3; i++) compare_active[i] <= 16'h0000;
    end else begin
      for (int i = 0; i < 3; i++) begin
        compare_active[i] <= phase_compare[i] & cmp_mask; // [R12]
        compare_extension[i] <= pwm_counter_control.pwm_eight_bit_mode ?
                                full_duty_active[2 - i] : phase_compare[i][15]; // [R12]
      end
    end
  end

endmodule : mpcef_top
`default_nettype wire

/* File: sim/mpcef_asserts.sv */
// checker: port-level properties of the chopper and event filter block
`timescale 1ns/1ps
`default_nettype none
module mpcef_asserts
  import mpcef_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic commutation_event,
  input wire logic update_event,
  input wire logic [15:0] pwm_period,
  input wire logic d_event,
  input wire logic blanking_active,
  input wire logic chop_signal,
  input wire logic chop_low_enable,
  input wire logic chop_high_enable,
  input wire logic [15:0] pwm_counter,
  input wire logic [2:0] full_duty_active,
  input wire logic [15:0] compare_active [3]
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // bus handshake
  wait_first_a: assert property ($rose(avs_read) || $rose(avs_write) |-> avs_waitrequest)
    else $error("no wait state on a new request");
  one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  upper_zero_a: assert property (avs_readdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  // ==========================================================
  // event filter and blanking
  blank_cause_a: assert property ($rose(blanking_active) |-> $past(commutation_event))
    else $error("blanking opened without a c event");
  d_single_a: assert property (d_event |=> !d_event)
    else $error("d event longer than one cycle");
  d_unblanked_a: assert property (d_event |-> !$past(blanking_active))
    else $error("d event from a blanked sample");
  // ==========================================================
  // chopper, duty override, compare format, counter
  chop_idle_a: assert property ((!chop_low_enable && !chop_high_enable) [*2] |-> !chop_signal)
    else $error("chopper runs while off");
  duty_cause_a: assert property ($changed(full_duty_active) |-> $past(update_event))
    else $error("full duty changed without update");
  cmp_mask_a: assert property ((compare_active[0][2:0] | compare_active[1][2:0]
    | compare_active[2][2:0]) == 3'h0)
    else $error("inactive compare bits set");
  counter_top_a: assert property (pwm_counter <= pwm_period)
    else $error("counter beyond period");
  c_devt: cover property (d_event);
  c_blank: cover property ($rose(blanking_active));
  c_duty: cover property (full_duty_active != 3'h0);
endmodule : mpcef_asserts

bind mpcef_top mpcef_asserts u_chk (.clock, .reset_n, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .commutation_event, .update_event, .pwm_period, .d_event,
  .blanking_active, .chop_signal, .chop_low_enable, .chop_high_enable, .pwm_counter,
  .full_duty_active, .compare_active);
`default_nettype wire

/* File: sim/mpcef_power_stage.sv */
// partner: inverter power stage comparator levels seen by the block
`timescale 1ns/1ps
`default_nettype none
module mpcef_power_stage (
  input wire logic clock,
  input wire logic [3:0] level,
  output logic [3:0] pins
);
  // comparators lag the winding by a clock, so the block never sees a level early
  always_ff @(posedge clock) begin
    pins <= level;
  end
endmodule : mpcef_power_stage
`default_nettype wire

/* File: sim/testbench.sv */
// testbench: register, filter, chopper and pwm scenarios against a bench model
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mpcef_pkg::*;
  localparam int unsigned BSTEP = 4;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, d_event, blank, cur_sel, chop, lo_en, hi_en, up, pend;
  logic tick = 1'b0;
  logic c_ev = 1'b0;
  logic u_ev = 1'b0;
  logic [3:0] lvl = 4'h0;
  logic [3:0] pins;
  logic [15:0] cnt, a;
  logic [2:0] fda, ext;
  logic [15:0] cmp [3] = '{16'h0, 16'h0, 16'h0};
  logic [15:0] act [3];
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed = 32'hbf36;
  int n, h1, h2;
  int regs [int];
  int cw [4] = '{0, 7, 8, 15};
  int fs [3] = '{0, 2, 15};
  // 25 MHz clock
  initial begin
    forever #20 clock = ~clock;
  end
  mpcef_power_stage ps (.clock(clock), .level(lvl), .pins(pins));
  mpcef_top #(.BLANK_STEP(BSTEP)) dut (.clock, .reset_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
    .sampling_clock_tick(tick), .commutation_event(c_ev), .update_event(u_ev),
    .d_event_raw(pins[3]), .bemf_comparator_in(pins[2]), .amplifier_output_cmp(pins[0]),
    .direct_current_feedback_cmp(pins[1]), .pwm_period(16'h0009), .phase_compare(cmp),
    .d_event, .blanking_active(blank), .current_input_select(cur_sel), .chop_signal(chop),
    .chop_low_enable(lo_en), .chop_high_enable(hi_en), .pwm_counter(cnt),
    .pwm_counting_up(up), .pwm_period_end(pend), .full_duty_active(fda),
    .compare_extension(ext), .compare_active(act));
  // ==========================================================
  // checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  // hang guard, well above the expected run length
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // ==========================================================
  // bus master and register model
  task automatic bus(input logic wr, input logic [3:0] ad, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clock);
    avs_address <= ad;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    // no local limit: a stuck slave is caught by the hang guard
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  // live comparator bits come from the stage levels, not from stored data
  function automatic logic [7:0] expv(input int ad);
    if (ad == 4) return {lvl[2], regs[4][5] ? lvl[1] : lvl[0], regs[4][5:0]};
    return regs.exists(ad) ? regs[ad][7:0] : 8'h00;
  endfunction : expv
  task automatic wr(input int ad, input int d);
    logic [7:0] q;
    bus(1'b1, ad[3:0], d[7:0], q);
    if (regs.exists(ad)) regs[ad] = d & (ad == 4 ? 8'h3F : ad == 12 ? 8'h01 : 8'hFF);
  endtask : wr
  task automatic rdchk(input int ad);
    logic [7:0] q;
    bus(1'b0, ad[3:0], 8'h00, q);
    check(q, expv(ad));
  endtask : rdchk
  // ==========================================================
  // stimulus helpers
  task automatic pulse(input int s);
    @(posedge clock);
    tick <= (s == 0);
    c_ev <= (s == 1);
    u_ev <= (s == 2);
    @(posedge clock);
    tick <= 1'b0;
    c_ev <= 1'b0;
    u_ev <= 1'b0;
  endtask : pulse
  function automatic logic [15:0] probe(input int s);
    return s ? cnt : {15'h0, chop};
  endfunction : probe
  // two adjacent intervals between changes of the probed output
  task automatic gap(input int s, output int g1, output int g2);
    logic [15:0] v;
    int m;
    int len [3] = '{0, 0, 0};
    m = 0;
    v = probe(s);
    for (int k = 0; k < 800 && m < 3; k++) begin
      @(posedge clock);
      if (m > 0) len[m]++;
      if (probe(s) !== v) begin
        v = probe(s);
        m++;
      end
    end
    g1 = len[1];
    g2 = len[2];
  endtask : gap
  // ==========================================================
  // main sequence
  initial begin
    regs[0] = 8'h0F;
    regs[4] = 0;
    regs[8] = 0;
    regs[12] = 0;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    for (int i = 0; i < 16; i += 2) rdchk(i);
    repeat (4) begin
      wr(0, $random(seed));
      wr(4, $random(seed));
      wr(2, $random(seed));
      rdchk(0);
      rdchk(4);
      rdchk(2);
    end
    @(posedge clock);
    lvl <= 4'h6;
    repeat (8) @(posedge clock);
    for (int s = 0; s < 2; s++) begin
      wr(4, s << 5);
      // let the newly chosen comparator input pass the synchroniser
      repeat (6) @(posedge clock);
      rdchk(4);
      check(cur_sel, s[0]);
    end
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      for (int r = 0; r < 8; r++) begin
        wr(4, m * 8 + r);
        repeat (3) @(posedge clock);
        #1;
        check({hi_en, lo_en}, m);
        if (m == 3) begin
          gap(0, h1, h2);
          check(h1, CLOCK_HZ / (2 * CHOP_HZ[r]));
          check(h2, CLOCK_HZ / (2 * CHOP_HZ[r]));
        end
      end
    end
    $display("test chopper done");
    for (int i = 0; i < 4; i++) begin
      wr(0, cw[i]);
      pulse(1);
      n = 0;
      repeat (200) begin
        @(posedge clock);
        n += (blank === 1'b1);
      end
      check(n, BSTEP * (cw[i] < 8 ? cw[i] + 1 : 4 * (cw[i] - 5)));
    end
    wr(12, 1);
    pulse(1);
    @(posedge clock);
    lvl <= 4'hE;
    n = 0;
    repeat (20) begin
      @(posedge clock);
      n += 2 * (blank === 1'b1) + (d_event === 1'b1);
    end
    check(n, 1);
    wr(12, 0);
    for (int i = 0; i < 3; i++) begin
      wr(0, fs[i] << 4);
      @(posedge clock);
      lvl <= 4'h6;
      repeat (6) @(posedge clock);
      pulse(0);
      @(posedge clock);
      lvl <= 4'hE;
      repeat (6) @(posedge clock);
      for (int j = 1; j <= fs[i] + 2; j++) begin
        pulse(0);
        // the pulse stands only in the cycle right after the tick edge
        #1;
        check(d_event, j == fs[i] + 1);
      end
    end
    $display("test event filter done");
    for (int p = 0; p < 3; p++) begin
      wr(8, 8'h40 >> p);
      rdchk(8);
      pulse(2);
      regs[8] = 0;
      @(posedge clock);
      #1;
      check(fda, 3'b100 >> p);
      rdchk(8);
      pulse(2);
      @(posedge clock);
      #1;
      check(fda, 3'h0);
    end
    for (int e = 0; e < 2; e++) begin
      @(posedge clock);
      for (int k = 0; k < 3; k++) cmp[k] <= 16'($random(seed));
      wr(8, e << 7);
      repeat (3) @(posedge clock);
      #1;
      for (int k = 0; k < 3; k++) check(act[k], cmp[k] & (e ? 16'hFF00 : 16'hFFF8));
      // no full duty bit is active here, so eight-bit mode extends with zero
      for (int k = 0; k < 3; k++) check(ext[k], e ? 1'b0 : cmp[k][15]);
    end
    for (int d = 0; d < 8; d++) begin
      wr(8, d);
      gap(1, h1, h2);
      check(h1, d + 1);
      check(up, 1'b1);
    end
    wr(8, 8'h08);
    for (int k = 0; k < 100 && up !== 1'b0; k++) @(posedge clock);
    // the turn at the top is flagged in the same cycle as the direction
    check(pend, 1'b1);
    repeat (2) @(posedge clock);
    a = cnt;
    @(posedge clock);
    check(cnt, a - 16'h1);
    $display("test pwm control done");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
